// [common/crpc_map.svh]
// Register indices, field positions, reset values and timing counts.
`ifndef CRPC_MAP_SVH
`define CRPC_MAP_SVH

// Register indices; the byte address is four times the index.
`define CRPC_IDX_WDT_CTRL     10'h0d3
`define CRPC_IDX_CLK_CTRL     10'h0d4
`define CRPC_IDX_STOP_GUARD   10'h010
`define CRPC_IDX_STATUS       10'h011

// Clock control fields and reset value.
`define CRPC_CLK_WAKE_DIS_BIT 7
`define CRPC_CLK_DIV_HI       4
`define CRPC_CLK_DIV_LO       3
`define CRPC_CLK_WR_MASK      8'h98
`define CRPC_CLK_RESET        8'h00

// Watchdog timer control fields and reset value.
`define CRPC_WDT_RESET        8'h00
`define CRPC_WDT_WR_MASK      8'hfc
`define CRPC_WDT_DISABLE_KEY  4'ha
`define CRPC_WDT_REFRESH_BIT  1
`define CRPC_WDT_STAB_HI      3
`define CRPC_WDT_STAB_LO      2

// Stop guard key and default.
`define CRPC_STOP_KEY         8'ha5
`define CRPC_STOP_GUARD_RESET 8'h00

// Opcodes that enter the power-down modes.
`define CRPC_OP_STOP          8'h7f
`define CRPC_OP_IDLE          8'h6f

// Reset vector and oscillator stabilization counts in clk_in cycles.
`define CRPC_RESET_VECTOR     16'h0100
`define CRPC_STAB_CNT_0       13'd4096
`define CRPC_STAB_CNT_1       13'd1024
`define CRPC_STAB_CNT_2       13'd256
`define CRPC_STAB_CNT_3       13'd64

// Division ratios minus one for each divider code.
`define CRPC_DIV16_LIM        4'hf
`define CRPC_DIV8_LIM         4'h7
`define CRPC_DIV2_LIM         4'h1
`define CRPC_DIV1_LIM         4'h0

// Bus responses.
`define CRPC_RESP_OKAY        2'b00
`define CRPC_RESP_SLVERR      2'b10

`endif

// [common/crpc_pkg.sv]
// Types shared by the clock, reset and power-down controller.
package crpc_pkg;

	typedef enum logic [2:0]
	{
		ST_RESET = 3'b000,
		ST_STAB  = 3'b001,
		ST_RUN   = 3'b010,
		ST_STOP  = 3'b011,
		ST_IDLE  = 3'b100
	} crpc_state_t;

	typedef logic [1:0] crpc_div_sel_t;

endpackage

// [hdl/crpc_clk_div.sv]
// Oscillator divider that issues one CPU clock enable tick per period.
`timescale 1ns/1ns
`include "crpc_map.svh"

module crpc_clk_div
(
	// Clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	// Control
	input  wire logic                   run_in,
	input  wire crpc_pkg::crpc_div_sel_t div_sel_in,
	// Tick
	output logic                        tick_out
);

	logic [3:0] count;

	// ****************************************************************
	// Division ratio
	// ****************************************************************
	function automatic logic [3:0] div_limit(input logic [1:0] sel);
		case (sel)
			2'b00:   div_limit = `CRPC_DIV16_LIM;
			2'b01:   div_limit = `CRPC_DIV8_LIM;
			2'b10:   div_limit = `CRPC_DIV2_LIM;
			default: div_limit = `CRPC_DIV1_LIM;
		endcase
	endfunction

	// A new ratio takes effect at once in the limit compare, so no long period occurs
	// even if the counter already passed the new limit.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || !run_in)
			count <= 4'h0;
		else if (count >= div_limit(div_sel_in))
			count <= 4'h0;
		else
			count <= count + 4'h1;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || !run_in)
			tick_out <= 1'b0;
		else
			tick_out <= (count >= div_limit(div_sel_in));
	end

endmodule

// [hdl/crpc_top.sv]
// Clock divider, reset sequencing and power-down control with AXI4-Lite.
// Summary of operation
// - Clock control register readable and writable at D4H.
// - CPU clock is oscillator divided by 1/2/8/16.
// - Bit 7 gates interrupt wake-up from Stop.
// - Reset: wake-up enabled, divide by 16.
// - Power-on, pin, watchdog, low-voltage reset; option bit.
// - External reset pin synchronised before use.
// - Reset forces control registers to defaults.
// - Watchdog overflow without refresh causes reset.
// - Low supply holds static reset until cleared.
// - Upper nibble 1010B disables watchdog reset.
// - Reset disables interrupts, inputs, loads vector.
// - Fetch only after stabilization interval expires.
// - Opcode 7FH enters Stop; oscillator halts. Here 7FH enters Stop only while the stop guard holds A5H.
// - Pin release ends Stop with full reset.
// - Only filtered external interrupts end Stop.
// - Interrupt wake keeps registers; programmed stabilization.
// - Stop wake services interrupt, then resumes.
// - Opcode 6FH enters Idle; CPU clock gated.
// - Reset ends Idle with defaults, divide 16.
// - Any enabled interrupt ends Idle, then serviced.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
`include "crpc_map.svh"

module crpc_top
#(
	parameter int          IRQ_WIDTH      = 7,
	parameter int          WDT_OVF_CYCLES = 65536,
	parameter logic [15:0] ALT_VECTOR     = 16'h0000
)
(
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	// AXI4-Lite write address and data
	input  wire logic [11:0]          s_axi_awaddr_in,
	input  wire logic                 s_axi_awvalid_in,
	output logic                      s_axi_awready_out,
	input  wire logic [31:0]          s_axi_wdata_in,
	input  wire logic [3:0]           s_axi_wstrb_in,
	input  wire logic                 s_axi_wvalid_in,
	output logic                      s_axi_wready_out,
	// AXI4-Lite write response
	output logic [1:0]                s_axi_bresp_out,
	output logic                      s_axi_bvalid_out,
	input  wire logic                 s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [11:0]          s_axi_araddr_in,
	input  wire logic                 s_axi_arvalid_in,
	output logic                      s_axi_arready_out,
	output logic [31:0]               s_axi_rdata_out,
	output logic [1:0]                s_axi_rresp_out,
	output logic                      s_axi_rvalid_out,
	input  wire logic                 s_axi_rready_in,
	// Reset sources and option straps
	input  wire logic                 external_reset_pin_n_in,
	input  wire logic                 low_voltage_detector_in,
	input  wire logic                 opt_ext_reset_in,
	input  wire logic                 opt_alt_vector_in,
	// CPU and interrupt side
	input  wire logic                 cpu_exec_in,
	input  wire logic [7:0]           cpu_opcode_in,
	input  wire logic [IRQ_WIDTH-1:0] filtered_external_irqs_in,
	input  wire logic                 enabled_irq_in,
	// Clock, reset and mode outputs
	output logic                      cpu_clk_en_out,
	output logic                      periph_clk_en_out,
	output logic                      osc_run_out,
	output logic                      sys_reset_out,
	output logic                      irq_disable_out,
	output logic                      ports_input_out,
	output logic                      vector_fetch_out,
	output logic [15:0]               reset_vector_out,
	output logic                      irq_service_out
);

	crpc_pkg::crpc_state_t state;
	logic [7:0]  system_clock_control;
	logic [7:0]  watchdog_timer_control;
	logic [7:0]  stop_guard_register;
	logic        pin_meta;
	logic        pin_sync;
	logic        opt_ext;
	logic        opt_alt;
	logic [16:0] wdt_count;
	logic        wdt_ovf;
	logic        wdt_enabled;
	logic        pin_reset;
	logic        rst_req;
	logic        soft_reset;
	logic [12:0] stab_cnt;
	logic        from_stop;
	logic        div_tick;
	logic        stop_hit;
	logic        idle_hit;
	logic        stop_wake;
	logic        aw_held;
	logic        w_held;
	logic [9:0]  aw_idx;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;

	// ****************************************************************
	// Reset sources
	// ****************************************************************
	// Straps are caught while the power-on reset is held.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			opt_ext <= opt_ext_reset_in;
			opt_alt <= opt_alt_vector_in;
		end
	end

	always_ff @(posedge clk_in)
	begin
		pin_meta <= external_reset_pin_n_in;
		pin_sync <= pin_meta;
	end

	assign pin_reset   = opt_ext && !pin_sync;
	assign wdt_enabled = watchdog_timer_control[7:4] !=
		`CRPC_WDT_DISABLE_KEY;
	assign wdt_ovf     = wdt_enabled &&
		(wdt_count == 17'(WDT_OVF_CYCLES - 1));
	assign rst_req     = pin_reset || low_voltage_detector_in || wdt_ovf;
	assign soft_reset  = !rst_n_in || rst_req || state == crpc_pkg::ST_RESET;

	// ****************************************************************
	// Watchdog counter
	// ****************************************************************
	always_ff @(posedge clk_in)
	begin
		if (soft_reset || !wdt_enabled)
			wdt_count <= 17'h00000;
		else if (do_write && aw_idx == `CRPC_IDX_WDT_CTRL && w_strb[0] &&
			w_data[`CRPC_WDT_REFRESH_BIT])
			wdt_count <= 17'h00000;
		else if (state != crpc_pkg::ST_STOP)
			wdt_count <= wdt_count + 17'h00001;
	end

	// ****************************************************************
	// Power sequencing state
	// ****************************************************************
	function automatic logic [12:0] stab_count(input logic [1:0] sel);
		case (sel)
			2'b00:   stab_count = `CRPC_STAB_CNT_0;
			2'b01:   stab_count = `CRPC_STAB_CNT_1;
			2'b10:   stab_count = `CRPC_STAB_CNT_2;
			default: stab_count = `CRPC_STAB_CNT_3;
		endcase
	endfunction

	assign stop_hit  = cpu_exec_in && cpu_opcode_in == `CRPC_OP_STOP &&
		stop_guard_register == `CRPC_STOP_KEY;
	assign idle_hit  = cpu_exec_in && cpu_opcode_in == `CRPC_OP_IDLE;
	assign stop_wake = (|filtered_external_irqs_in) &&
		!system_clock_control[`CRPC_CLK_WAKE_DIS_BIT];

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || rst_req)
			state <= crpc_pkg::ST_RESET;
		else
			case (state)
				crpc_pkg::ST_RESET: state <= crpc_pkg::ST_STAB;
				crpc_pkg::ST_STAB:
					if (stab_cnt == 13'h0000)
						state <= crpc_pkg::ST_RUN;
				crpc_pkg::ST_RUN:
					if (stop_hit)
						state <= crpc_pkg::ST_STOP;
					else if (idle_hit)
						state <= crpc_pkg::ST_IDLE;
				crpc_pkg::ST_STOP:
					if (stop_wake)
						state <= crpc_pkg::ST_STAB;
				crpc_pkg::ST_IDLE:
					if (enabled_irq_in)
						state <= crpc_pkg::ST_RUN;
				default: state <= crpc_pkg::ST_RESET;
			endcase
	end

	// The interval is sampled from the control register every cycle
	// outside the wait, so a Stop wake uses the programmed value.
	always_ff @(posedge clk_in)
	begin
		if (state != crpc_pkg::ST_STAB)
			stab_cnt <= stab_count(watchdog_timer_control[
				`CRPC_WDT_STAB_HI:`CRPC_WDT_STAB_LO]);
		else if (stab_cnt != 13'h0000)
			stab_cnt <= stab_cnt - 13'h0001;
	end

	always_ff @(posedge clk_in)
	begin
		if (soft_reset)
			from_stop <= 1'b0;
		else if (state == crpc_pkg::ST_STOP)
			from_stop <= 1'b1;
		else if (state == crpc_pkg::ST_RUN)
			from_stop <= 1'b0;
	end

	// ****************************************************************
	// Clock divider
	// ****************************************************************
	crpc_clk_div u_div
	(
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.run_in     (state != crpc_pkg::ST_STOP),
		.div_sel_in (system_clock_control[
			`CRPC_CLK_DIV_HI:`CRPC_CLK_DIV_LO]),
		.tick_out   (div_tick)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			cpu_clk_en_out    <= 1'b0;
			periph_clk_en_out <= 1'b0;
			osc_run_out       <= 1'b1;
		end
		else
		begin
			cpu_clk_en_out    <= div_tick &&
				state == crpc_pkg::ST_RUN;
			periph_clk_en_out <= div_tick &&
				(state == crpc_pkg::ST_RUN || state == crpc_pkg::ST_IDLE);
			osc_run_out       <= state != crpc_pkg::ST_STOP;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in || rst_req)
		begin
			sys_reset_out   <= 1'b1;
			irq_disable_out <= 1'b1;
			ports_input_out <= 1'b1;
		end
		else
		begin
			sys_reset_out   <= state == crpc_pkg::ST_RESET;
			irq_disable_out <= state == crpc_pkg::ST_RESET;
			ports_input_out <= state == crpc_pkg::ST_RESET;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			vector_fetch_out <= 1'b0;
			irq_service_out  <= 1'b0;
			reset_vector_out <= `CRPC_RESET_VECTOR;
		end
		else
		begin
			vector_fetch_out <= !rst_req && state == crpc_pkg::ST_STAB &&
				stab_cnt == 13'h0000 && !from_stop;
			irq_service_out  <= !rst_req &&
				((state == crpc_pkg::ST_STAB && stab_cnt == 13'h0000 &&
				from_stop) ||
				(state == crpc_pkg::ST_IDLE && enabled_irq_in));
			reset_vector_out <= opt_alt ? ALT_VECTOR :
				`CRPC_RESET_VECTOR;
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	assign do_write = aw_held && w_held && !s_axi_bvalid_out;

	always_ff @(posedge clk_in)
	begin
		if (soft_reset)
			system_clock_control <= `CRPC_CLK_RESET;
		else if (do_write && aw_idx == `CRPC_IDX_CLK_CTRL && w_strb[0])
			system_clock_control <= w_data[7:0] & `CRPC_CLK_WR_MASK;
	end

	always_ff @(posedge clk_in)
	begin
		if (soft_reset)
			watchdog_timer_control <= `CRPC_WDT_RESET;
		else if (do_write && aw_idx == `CRPC_IDX_WDT_CTRL && w_strb[0])
			watchdog_timer_control <= w_data[7:0] & `CRPC_WDT_WR_MASK;
	end

	always_ff @(posedge clk_in)
	begin
		if (soft_reset)
			stop_guard_register <= `CRPC_STOP_GUARD_RESET;
		else if (do_write && aw_idx == `CRPC_IDX_STOP_GUARD && w_strb[0])
			stop_guard_register <= w_data[7:0];
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	function automatic logic known_idx(input logic [9:0] idx);
		known_idx = idx == `CRPC_IDX_CLK_CTRL || idx == `CRPC_IDX_WDT_CTRL ||
			idx == `CRPC_IDX_STOP_GUARD || idx == `CRPC_IDX_STATUS;
	endfunction

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			aw_held           <= 1'b0;
			w_held            <= 1'b0;
			aw_idx            <= 10'h000;
			w_data            <= 32'h00000000;
			w_strb            <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= `CRPC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_held           <= 1'b1;
				aw_idx            <= s_axi_awaddr_in[11:2];
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_held           <= 1'b1;
				w_data           <= s_axi_wdata_in;
				w_strb           <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= known_idx(aw_idx) ?
					`CRPC_RESP_OKAY : `CRPC_RESP_SLVERR;
			end
			else if (s_axi_bvalid_out && s_axi_bready_in)
			begin
				s_axi_bvalid_out  <= 1'b0;
				aw_held           <= 1'b0;
				w_held            <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h00000000;
			s_axi_rresp_out   <= `CRPC_RESP_OKAY;
		end
		else if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rresp_out   <= known_idx(s_axi_araddr_in[11:2]) ?
				`CRPC_RESP_OKAY : `CRPC_RESP_SLVERR;
			case (s_axi_araddr_in[11:2])
				`CRPC_IDX_CLK_CTRL:
					s_axi_rdata_out <= {24'h000000, system_clock_control};
				`CRPC_IDX_WDT_CTRL:
					s_axi_rdata_out <= {24'h000000, watchdog_timer_control};
				`CRPC_IDX_STOP_GUARD:
					s_axi_rdata_out <= {24'h000000, stop_guard_register};
				`CRPC_IDX_STATUS:
					s_axi_rdata_out <= {24'h000000, opt_ext, from_stop,
						wdt_enabled, 2'b00, state};
				default: s_axi_rdata_out <= 32'h00000000;
			endcase
		end
		else if (s_axi_rvalid_out && s_axi_rready_in)
		begin
			s_axi_rvalid_out  <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	clk_reset_a: assert property (state == crpc_pkg::ST_RESET |->
		system_clock_control == 8'h00)
		else $error("clock control not at default during reset");
	pin_sync_a: assert property (opt_ext && !external_reset_pin_n_in |->
		##[1:3] state == crpc_pkg::ST_RESET)
		else $error("external reset pin not acted on in time");
	lvd_hold_a: assert property (low_voltage_detector_in |=>
		state == crpc_pkg::ST_RESET && sys_reset_out)
		else $error("low supply did not hold reset");
	wdt_reset_a: assert property (wdt_ovf |=>
		state == crpc_pkg::ST_RESET)
		else $error("watchdog overflow did not reset");
	wdt_off_a: assert property (watchdog_timer_control[7:4] == 4'ha |->
		!wdt_ovf)
		else $error("disabled watchdog overflowed");
	stop_entry_a: assert property (state == crpc_pkg::ST_RUN && stop_hit &&
		!rst_req |=> state == crpc_pkg::ST_STOP ##1 !osc_run_out)
		else $error("stop entry or oscillator halt failed");
	wake_block_a: assert property (state == crpc_pkg::ST_STOP &&
		system_clock_control[7] && !rst_req |=>
		state == crpc_pkg::ST_STOP)
		else $error("stop left with wake-up disabled");
	irq_keep_a: assert property (state == crpc_pkg::ST_STOP ##1
		state == crpc_pkg::ST_STAB |->
		system_clock_control == $past(system_clock_control))
		else $error("interrupt wake changed clock control");
	idle_wake_a: assert property (state == crpc_pkg::ST_IDLE &&
		enabled_irq_in && !rst_req |=>
		state == crpc_pkg::ST_RUN && irq_service_out)
		else $error("idle not released by interrupt");
	idle_gate_a: assert property (state == crpc_pkg::ST_IDLE |=>
		!cpu_clk_en_out)
		else $error("cpu clock ran in idle");
	stab_done_a: assert property (state == crpc_pkg::ST_STAB &&
		stab_cnt == 13'h0000 && !rst_req && !from_stop |=>
		state == crpc_pkg::ST_RUN && vector_fetch_out)
		else $error("vector fetch not issued after stabilization");

endmodule

// [testbench/crpc_cpu_model.sv]
// Behavioural CPU, interrupt and reset-pin side of the controller.
`timescale 1ns/1ns

module crpc_cpu_model
(
	// Clock
	input  wire logic clk_in,
	// Lines toward the controller
	output logic       exec_out,
	output logic [7:0] opcode_out,
	output logic [6:0] irqs_out,
	output logic       enabled_irq_out,
	output logic       pin_n_out,
	output logic       lvd_out
);
	initial
	begin
		exec_out = 1'b0;
		opcode_out = 8'h00;
		irqs_out = 7'h00;
		enabled_irq_out = 1'b0;
		pin_n_out = 1'b1;
		lvd_out = 1'b0;
	end

	// Outside the pulse the opcode bus shows the inverse, never stale data.
	task automatic exec(input logic [7:0] op);
		@(posedge clk_in);
		exec_out <= 1'b1;
		opcode_out <= op;
		@(posedge clk_in);
		exec_out <= 1'b0;
		opcode_out <= ~op;
	endtask

	task automatic lines(input logic [6:0] irq, input logic en,
		input logic pin_n, input logic lvd);
		@(posedge clk_in);
		irqs_out <= irq;
		enabled_irq_out <= en;
		pin_n_out <= pin_n;
		lvd_out <= lvd;
	endtask
endmodule

// [testbench/crpc_top_test.sv]
// Self-checking bench for the clock, reset and power-down controller.
`timescale 1ns/1ns
`include "crpc_map.svh"

module crpc_top_test;
	localparam logic [11:0] A_WDT = {`CRPC_IDX_WDT_CTRL, 2'b00};
	localparam logic [11:0] A_CLK = {`CRPC_IDX_CLK_CTRL, 2'b00};
	localparam logic [11:0] A_GRD = {`CRPC_IDX_STOP_GUARD, 2'b00};
	localparam logic [11:0] A_STA = {`CRPC_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_BAD = 12'hffc;
	// Alternate vector for the option strap; the value is arbitrary.
	localparam logic [15:0] A_VEC = 16'h0240;
	logic clk_in, rst_n_in;
	logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd;
	logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
	logic s_axi_arvalid_in, s_axi_rready_in;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
	logic cpu_exec_in, enabled_irq_in, external_reset_pin_n_in;
	logic low_voltage_detector_in;
	logic [7:0] cpu_opcode_in;
	logic [6:0] filtered_external_irqs_in;
	logic cpu_clk_en_out, periph_clk_en_out, osc_run_out, sys_reset_out;
	logic irq_disable_out, ports_input_out, vector_fetch_out;
	logic irq_service_out;
	logic [15:0] reset_vector_out;
	logic opt_ext_reset_in, opt_alt_vector_in;
	int n_errors, compares, n, p;

	crpc_top #(.IRQ_WIDTH(7), .WDT_OVF_CYCLES(6000),
		.ALT_VECTOR(A_VEC)) i_crpc_top
	(
		.clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
		.s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in(4'hf),
		.s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
		.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
		.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
		.s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
		.external_reset_pin_n_in, .low_voltage_detector_in,
		.opt_ext_reset_in, .opt_alt_vector_in, .cpu_exec_in,
		.cpu_opcode_in, .filtered_external_irqs_in, .enabled_irq_in,
		.cpu_clk_en_out, .periph_clk_en_out, .osc_run_out, .sys_reset_out,
		.irq_disable_out, .ports_input_out, .vector_fetch_out,
		.reset_vector_out, .irq_service_out
	);

	crpc_cpu_model i_crpc_cpu_model
	(
		.clk_in, .exec_out(cpu_exec_in), .opcode_out(cpu_opcode_in),
		.irqs_out(filtered_external_irqs_in), .enabled_irq_out(enabled_irq_in),
		.pin_n_out(external_reset_pin_n_in), .lvd_out(low_voltage_detector_in)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	// The run needs about 33000 cycles; the limit leaves ample margin.
	initial
	begin
		#8000000;
		n_errors++;
		finish_test();
	end

	task automatic finish_test();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: %s seen %h", $time, msg, seen);
		end
	endtask

	task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge clk_in);
			if (!aw_ok && s_axi_awready_out === 1'b1)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid_in <= 1'b0;
			end
			if (!w_ok && s_axi_wready_out === 1'b1)
			begin
				w_ok = 1'b1;
				s_axi_wvalid_in <= 1'b0;
			end
		end
		s_axi_bready_in <= 1'b1;
		do @(posedge clk_in); while (s_axi_bvalid_out !== 1'b1);
		rs = s_axi_bresp_out;
		s_axi_bready_in <= 1'b0;
	endtask

	task automatic axi_read(input logic [11:0] a);
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		do @(posedge clk_in); while (s_axi_arready_out !== 1'b1);
		s_axi_arvalid_in <= 1'b0;
		s_axi_rready_in <= 1'b1;
		do @(posedge clk_in); while (s_axi_rvalid_out !== 1'b1);
		rd = s_axi_rdata_out;
		rs = s_axi_rresp_out;
		s_axi_rready_in <= 1'b0;
	endtask

	// Sel 0 waits for the vector fetch, 1 for service, 2 for reset.
	task automatic wait_pulse(input int sel, input int lim);
		logic s;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
			s = sel == 0 ? vector_fetch_out : sel == 1 ? irq_service_out
				: sys_reset_out;
		end while (s !== 1'b1 && n < lim);
		check(s, 1'b1, "pulse missing");
	endtask

	task automatic t_reset();
		check({irq_disable_out, ports_input_out, sys_reset_out}, 3'h7, "rst");
		rst_n_in <= 1'b1;
		wait_pulse(0, 5000);
		check(n >= 4096, 1'b1, "stabilization short");
		check(reset_vector_out, `CRPC_RESET_VECTOR, "vector");
		axi_read(A_CLK);
		check(rd, 32'h0, "clock control default");
		axi_read(A_STA);
		check({rd[5], rd[2:0]}, 4'ha, "status after reset");
		axi_write(A_WDT, 32'h2);
		wait_pulse(2, 7000);
		check(n > 3000, 1'b1, "refresh ignored");
		wait_pulse(0, 5000);
		axi_write(A_WDT, 32'hac);
		axi_read(A_STA);
		check(rd[5], 1'b0, "watchdog still on");
		p = 0;
		repeat (6100) @(posedge clk_in) p += sys_reset_out;
		check(p, 0, "watchdog reset");
		$display("test reset_watchdog done");
	endtask

	task automatic t_regs();
		int e[4] = '{16, 8, 2, 1};
		axi_write(A_CLK, 32'hff);
		check(rs, `CRPC_RESP_OKAY, "write response");
		axi_read(A_CLK);
		check(rd, 32'h98, "clock control rw");
		check(rs, `CRPC_RESP_OKAY, "read response");
		axi_write(A_BAD, 32'h1);
		check(rs, `CRPC_RESP_SLVERR, "unmapped write");
		axi_read(A_BAD);
		check(rs, `CRPC_RESP_SLVERR, "unmapped read");
		check(rd, 32'h0, "unmapped read data");
		for (int i = 0; i < 4; i++)
		begin
			axi_write(A_CLK, i << 3);
			repeat (3)
			begin
				p = 0;
				do @(posedge clk_in); while (cpu_clk_en_out !== 1'b1 && ++p < 40);
			end
			check(p + 1, e[i], "divider period");
		end
		$display("test registers_divider done");
	endtask

	task automatic t_idle();
		i_crpc_cpu_model.exec(`CRPC_OP_IDLE);
		axi_read(A_STA);
		check(rd[2:0], 3'h4, "idle state");
		n = 0;
		p = 0;
		repeat (32) @(posedge clk_in)
		begin
			n += cpu_clk_en_out;
			p += periph_clk_en_out;
		end
		check({n == 0, p > 0}, 2'h3, "idle clocks");
		i_crpc_cpu_model.lines(7'h00, 1'b1, 1'b1, 1'b0);
		wait_pulse(1, 20);
		i_crpc_cpu_model.lines(7'h00, 1'b0, 1'b1, 1'b0);
		axi_read(A_STA);
		check(rd[2:0], 3'h2, "idle exit");
		axi_read(A_CLK);
		check(rd, 32'h18, "divider kept");
		$display("test idle done");
	endtask

	task automatic t_stop();
		i_crpc_cpu_model.exec(`CRPC_OP_STOP);
		axi_read(A_STA);
		check(rd[2:0], 3'h2, "stop without guard");
		axi_write(A_GRD, `CRPC_STOP_KEY);
		axi_write(A_CLK, 32'h90);
		i_crpc_cpu_model.exec(`CRPC_OP_STOP);
		axi_read(A_STA);
		check({osc_run_out, rd[2:0]}, 4'h3, "stop entry");
		i_crpc_cpu_model.lines(7'h01, 1'b1, 1'b1, 1'b0);
		repeat (50) @(posedge clk_in);
		axi_read(A_STA);
		check(rd[2:0], 3'h3, "wake while disabled");
		i_crpc_cpu_model.lines(7'h00, 1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge clk_in);
		check(sys_reset_out, 1'b1, "pin reset");
		i_crpc_cpu_model.lines(7'h00, 1'b0, 1'b1, 1'b0);
		wait_pulse(0, 5000);
		axi_write(A_WDT, 32'hac);
		axi_read(A_CLK);
		check(rd, 32'h0, "clock after pin reset");
		axi_write(A_CLK, 32'h10);
		axi_write(A_GRD, `CRPC_STOP_KEY);
		i_crpc_cpu_model.exec(`CRPC_OP_STOP);
		i_crpc_cpu_model.lines(7'h02, 1'b0, 1'b1, 1'b0);
		wait_pulse(1, 400);
		check({n >= 64, osc_run_out}, 2'h3, "stop wake timing");
		i_crpc_cpu_model.lines(7'h00, 1'b0, 1'b1, 1'b0);
		axi_read(A_STA);
		check(rd[2:0], 3'h2, "running after wake");
		axi_read(A_CLK);
		check(rd, 32'h10, "clock kept on wake");
		$display("test stop done");
	endtask

	task automatic t_lvd();
		axi_write(A_CLK, 32'h18);
		i_crpc_cpu_model.exec(`CRPC_OP_IDLE);
		i_crpc_cpu_model.lines(7'h00, 1'b0, 1'b1, 1'b1);
		repeat (40) @(posedge clk_in);
		check(sys_reset_out, 1'b1, "low supply reset");
		axi_read(A_STA);
		check(rd[2:0], 3'h0, "held in reset");
		i_crpc_cpu_model.lines(7'h00, 1'b0, 1'b1, 1'b0);
		wait_pulse(0, 5000);
		axi_read(A_CLK);
		check(rd, 32'h0, "idle reset defaults");
		$display("test low_voltage done");
	endtask

	// Straps are taken only while the power-on reset is held.
	task automatic t_opt();
		opt_ext_reset_in <= 1'b0;
		opt_alt_vector_in <= 1'b1;
		rst_n_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		wait_pulse(0, 5000);
		check(reset_vector_out, A_VEC, "option vector");
		axi_read(A_STA);
		check(rd[7], 1'b0, "option status");
		i_crpc_cpu_model.lines(7'h00, 1'b0, 1'b0, 1'b0);
		p = 0;
		repeat (10) @(posedge clk_in) p += sys_reset_out;
		check(p, 0, "pin acted without option");
		i_crpc_cpu_model.lines(7'h00, 1'b0, 1'b1, 1'b0);
		$display("test reset_option done");
	endtask

	initial
	begin
		n_errors = 0;
		compares = 0;
		rst_n_in = 1'b0;
		opt_ext_reset_in = 1'b1;
		opt_alt_vector_in = 1'b0;
		s_axi_awaddr_in = 12'h000;
		s_axi_araddr_in = 12'h000;
		s_axi_wdata_in = 32'h0;
		s_axi_awvalid_in = 1'b0;
		s_axi_wvalid_in = 1'b0;
		s_axi_bready_in = 1'b0;
		s_axi_arvalid_in = 1'b0;
		s_axi_rready_in = 1'b0;
		repeat (3) @(posedge clk_in);
		t_reset();
		t_regs();
		t_idle();
		t_stop();
		t_lvd();
		t_opt();
		finish_test();
	end
endmodule
